// *** hdl/mar_regs.svh ***
`ifndef MAR_REGS_SVH
`define MAR_REGS_SVH
`define MAR_NUM_AXES 4
`define MAR_AXIS_W 2
`define MAR_FUNC_W 8
`define MAR_FIFO_DEPTH 16
`define MAR_PKT_W 58
`define MAR_FUNC_READ_POS 8'h10
`define MAR_FUNC_READ_VEL 8'h11
`define MAR_FUNC_READ_STEPS_VEL 8'h12
`define MAR_SERVO_POS_MAX 32'sh3FFFFFFF
`define MAR_SERVO_POS_MIN 32'shC0000000
`define MAR_SERVO_VEL_MAX 16'sh3FFF
`define MAR_SERVO_VEL_MIN 16'shC000
`define MAR_STEP_RATE_MIN 32'h00000001
`define MAR_STEP_RATE_MAX 32'h00100000
`define MAR_RATE_W 21
`define MAR_VEL_INT_HI 31
`define MAR_VEL_INT_LO 16
`endif

// *** hdl/mar_pkg.sv ***
package mar_pkg;
    typedef enum logic [1:0] {
        MAR_OP_RELATIVE,
        MAR_OP_ABSOLUTE,
        MAR_OP_VELOCITY
    } mar_op_mode_e;
    typedef enum logic {
        MAR_ST_IDLE,
        MAR_ST_SEND
    } mar_drain_e;
endpackage

// *** hdl/mar_fifo.sv ***
`timescale 1ns/100ps
module mar_fifo #(
    parameter int WIDTH = 58,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign level = count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
    // storage has no reset; entries are read only after being written
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// *** hdl/mar_readback.sv ***
// Summary of operation
// [R1] position read samples the chosen axis counter in the executing cycle
// [R2] sampled position sits in the return buffer until the host reads it
// [R3] servo position is 32-bit encoder counts, limited to plus/minus two to thirty
// [R4] stepper position is a full-range signed 32-bit step count
// [R5] programmed offset and scale are applied to the reported position
// [R6] stepper position reads zero in velocity mode
// [R7] packet holds function code, axis, two 16-bit words and a data flag
// [R8] host asks for one or more packets; only held packets are returned
// [R9] host drains the buffer with its retrieval mode two
// [R10] stepper velocity is unsigned steps per second, 1 to 1,048,576
// [R11] stepper velocity unsigned; direction shown in axis status word
// [R12] generated step rate never exceeds the axis maximum programmed one cycle earlier
// [R13] servo velocity is signed 16-bit counts per sample, limited range
// [R14] servo velocity held 16.16; readback gives integer half only
// [R15] servo velocity sign gives direction, positive forward
// [R16] packets leave the buffer in completion order
`timescale 1ns/100ps
`include "mar_regs.svh"
module mar_readback
    import mar_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stepper_variant,
    input wire logic [1:0] op_mode,
    input wire logic [4*32-1:0] axis_position,
    input wire logic [4*32-1:0] axis_servo_vel,
    input wire logic [4*32-1:0] axis_step_rate_req,
    input wire logic [4*32-1:0] axis_max_rate,
    input wire logic [3:0] axis_dir_reverse,
    input wire logic [4*32-1:0] pos_offset,
    input wire logic [4*16-1:0] pos_scale,
    input wire logic [3:0] scale_enable,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [`MAR_FUNC_W-1:0] function_code,
    input wire logic [`MAR_AXIS_W-1:0] cmd_axis,
    input wire logic drain_start,
    input wire logic [15:0] drain_count,
    output logic drain_busy,
    output logic drain_refused,
    output logic pkt_valid,
    input wire logic pkt_ready,
    output logic [`MAR_FUNC_W-1:0] pkt_function_code,
    output logic [`MAR_AXIS_W-1:0] pkt_axis,
    output logic [15:0] pkt_word_hi,
    output logic [15:0] pkt_word_lo,
    output logic pkt_has_data,
    output logic [4*32-1:0] axis_step_rate,
    output logic [4*16-1:0] axis_status,
    output logic [4:0] buffer_level
);
    logic [`MAR_PKT_W-1:0] fifo_in;
    logic [`MAR_PKT_W-1:0] fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] payload;
    logic payload_ok;
    mar_drain_e state;
    mar_drain_e next_state;
    logic [15:0] remain;
    logic [15:0] next_remain;
    logic refused;
    logic next_refused;

    function automatic logic [31:0] lane32(input logic [4*32-1:0] v, input logic [1:0] a);
        lane32 = v[a*32 +: 32];
    endfunction

    function automatic logic signed [31:0] sat_pos(input logic signed [63:0] v,
                                                   input logic stepper);
        logic signed [63:0] hi;
        logic signed [63:0] lo;
        hi = stepper ? 64'sh000000007FFFFFFF : 64'(`MAR_SERVO_POS_MAX);
        lo = stepper ? 64'shFFFFFFFF80000000 : 64'(`MAR_SERVO_POS_MIN);
        if (v > hi) begin
            sat_pos = hi[31:0];
        end else if (v < lo) begin
            sat_pos = lo[31:0];
        end else begin
            sat_pos = v[31:0];
        end
    endfunction

    // step generator clamps the requested rate to the axis maximum
    genvar g;
    generate
        for (g = 0; g < `MAR_NUM_AXES; g++) begin : g_axis
            logic [31:0] req;
            logic [31:0] lim;
            logic [31:0] next_rate;
            logic [31:0] rate;
            assign req = axis_step_rate_req[g*32 +: 32];
            assign lim = axis_max_rate[g*32 +: 32];
            always_comb begin
                next_rate = (req > lim) ? lim : req; // [R12]
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rate <= '0;
                end else begin
                    rate <= next_rate;
                end
            end
            assign axis_step_rate[g*32 +: 32] = rate;
            // direction lives in the status word, not in the velocity
            assign axis_status[g*16 +: 16] = {15'h0000, axis_dir_reverse[g]}; // [R11]
        end
    endgenerate

    // payload formed in the executing cycle so the live counter is captured there
    always_comb begin
        logic signed [63:0] scaled;
        logic signed [31:0] raw;
        logic signed [31:0] vint;
        logic [31:0] rate;
        scaled = '0;
        raw = '0;
        vint = '0;
        rate = '0;
        payload = '0;
        payload_ok = 1'b0;
        raw = lane32(axis_position, cmd_axis); // [R1]
        scaled = 64'(raw) + 64'(signed'(lane32(pos_offset, cmd_axis))); // [R5]
        if (scale_enable[cmd_axis]) begin
            scaled = 64'(raw) * 64'(signed'({1'b0, pos_scale[cmd_axis*16 +: 16]}))
                   + 64'(signed'(lane32(pos_offset, cmd_axis))); // [R5]
        end
        unique case (function_code)
            `MAR_FUNC_READ_POS: begin
                payload_ok = 1'b1;
                if (stepper_variant && op_mode == MAR_OP_VELOCITY) begin
                    payload = '0; // [R6]
                end else begin
                    payload = sat_pos(scaled, stepper_variant); // [R3] [R4]
                end
            end
            `MAR_FUNC_READ_VEL: begin
                payload_ok = !stepper_variant;
                // upper half is integer part; sign kept for direction
                // cast before the shift so the arithmetic shift keeps the sign
                vint = signed'(lane32(axis_servo_vel, cmd_axis)) >>>
                       `MAR_VEL_INT_LO; // [R14] [R15]
                if (vint > 32'(`MAR_SERVO_VEL_MAX)) begin
                    vint = 32'(`MAR_SERVO_VEL_MAX);
                end else if (vint < 32'(`MAR_SERVO_VEL_MIN)) begin
                    vint = 32'(`MAR_SERVO_VEL_MIN);
                end
                payload = {16'h0000, vint[15:0]}; // [R13]
            end
            `MAR_FUNC_READ_STEPS_VEL: begin
                payload_ok = stepper_variant;
                rate = lane32(axis_step_rate, cmd_axis);
                if (rate < `MAR_STEP_RATE_MIN) begin
                    rate = `MAR_STEP_RATE_MIN;
                end else if (rate > `MAR_STEP_RATE_MAX) begin
                    rate = `MAR_STEP_RATE_MAX;
                end
                payload = rate; // [R10] [R11]
            end
            default: begin
                payload_ok = 1'b0;
            end
        endcase
    end

    // full buffer stalls the command side rather than dropping a result
    assign cmd_ready = fifo_in_ready;
    assign fifo_in_valid = cmd_valid;
    assign fifo_in = {function_code, cmd_axis, payload_ok,
                      payload_ok ? payload : 32'h00000000, 15'h0000}; // [R7]

    mar_fifo #(
        .WIDTH(`MAR_PKT_W),
        .DEPTH(`MAR_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out),
        .level(buffer_level)
    ); // [R2] [R16]

    // drain sequencer for the host retrieval request
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_refused = 1'b0;
        unique case (state)
            MAR_ST_IDLE: begin
                if (drain_start) begin
                    if (drain_count == 16'h0000) begin
                        next_refused = 1'b1; // [R8]
                    end else begin
                        next_state = MAR_ST_SEND; // [R9]
                        next_remain = drain_count;
                    end
                end
            end
            MAR_ST_SEND: begin
                if (pkt_valid && pkt_ready) begin
                    next_remain = remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        next_state = MAR_ST_IDLE;
                    end
                end else if (!fifo_out_valid) begin
                    next_state = MAR_ST_IDLE; // [R8]
                    next_remain = 16'h0000;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= MAR_ST_IDLE;
            remain <= '0;
            refused <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            refused <= next_refused;
        end
    end

    assign drain_busy = (state == MAR_ST_SEND);
    assign drain_refused = refused;
    assign pkt_valid = drain_busy && fifo_out_valid;
    assign fifo_out_ready = drain_busy && pkt_ready; // [R2]
    assign pkt_function_code = fifo_out[57:50];
    assign pkt_axis = fifo_out[49:48];
    assign pkt_has_data = fifo_out[47];
    assign pkt_word_hi = fifo_out[46:31];
    assign pkt_word_lo = fifo_out[30:15];
endmodule

// *** verif/mar_readback_props.sv ***
`timescale 1ns/100ps
module mar_readback_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic drain_start,
    input wire logic [15:0] drain_count,
    input wire logic drain_busy,
    input wire logic drain_refused,
    input wire logic pkt_valid,
    input wire logic pkt_ready,
    input wire logic [4*32-1:0] axis_max_rate,
    input wire logic [3:0] axis_dir_reverse,
    input wire logic [4*32-1:0] axis_step_rate,
    input wire logic [4*16-1:0] axis_status,
    input wire logic [4:0] buffer_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic push = cmd_valid && cmd_ready;
    wire logic pop = pkt_valid && pkt_ready;
    wire logic go = drain_start && !drain_busy;
    a_push_grows: assert property (push && !pop |=> buffer_level == $past(buffer_level) + 5'h01)
        else $error("level did not grow on push");
    a_pop_shrinks: assert property (pop && !push |=> buffer_level == $past(buffer_level) - 5'h01)
        else $error("level did not shrink on pop");
    a_full_refuse: assert property (buffer_level == 5'h10 |-> !cmd_ready)
        else $error("full buffer took a command");
    a_empty_silent: assert property (buffer_level == 5'h00 |-> !pkt_valid)
        else $error("packet offered from empty buffer");
    a_zero_refused: assert property (go && drain_count == 16'h0000 |=> drain_refused)
        else $error("zero count not refused");
    a_drain_opens: assert property (go && drain_count != 16'h0000 |=> drain_busy)
        else $error("drain did not start");
    a_rate_capped: assert property ($stable(axis_max_rate) |-> axis_step_rate[31:0] <= axis_max_rate[31:0])
        else $error("step rate above axis maximum");
    a_rate_range: assert property (axis_step_rate[63:32] <= 32'h00100000)
        else $error("step rate out of range");
    a_dir_status: assert property (axis_status[16] == axis_dir_reverse[1])
        else $error("status direction wrong");
    c_full: cover property (buffer_level == 5'h10);
    c_stall: cover property (pkt_valid && !pkt_ready);
    c_refuse: cover property (drain_refused);
endmodule

// *** verif/mar_host_model.sv ***
`timescale 1ns/100ps
module mar_host_model (
    input wire logic clk,
    output logic drain_start,
    output logic [15:0] drain_count,
    input wire logic drain_busy,
    output logic pkt_ready
);
    localparam int RETRIEVE_MODE = 2;
    initial begin
        drain_start = 1'b0;
        drain_count = 16'h0000;
        pkt_ready = 1'b0;
    end
    // a slow host stalls every other cycle
    task automatic retrieve(input logic [15:0] n, input bit slow);
        int k;
        @(negedge clk);
        drain_start = 1'b1;
        drain_count = n;
        pkt_ready = !slow;
        @(negedge clk);
        drain_start = 1'b0;
        drain_count = ~n;
        for (k = 0; k < 200 && drain_busy; k++) begin
            @(negedge clk);
            pkt_ready = slow ? ~pkt_ready : 1'b1;
        end
        pkt_ready = 1'b0;
    endtask
endmodule

// *** verif/test_motion_axis_readback.sv ***
`timescale 1ns/100ps
`include "mar_regs.svh"
module test_motion_axis_readback;
    import mar_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stepper_variant = 1'b0;
    logic [1:0] op_mode = 2'h0;
    logic [127:0] axis_position = '0, axis_servo_vel = '0, axis_step_rate_req = '0, pos_offset = '0;
    logic [127:0] axis_max_rate = {4{32'hFFFFFFFF}}, axis_step_rate;
    logic [3:0] axis_dir_reverse = 4'h0, scale_enable = 4'h0;
    logic [63:0] pos_scale = '0, axis_status;
    logic cmd_valid = 1'b0;
    logic [7:0] function_code = 8'h00, pkt_function_code;
    logic [1:0] cmd_axis = 2'h0, pkt_axis;
    logic drain_start, drain_busy, drain_refused, pkt_valid, pkt_ready, pkt_has_data, cmd_ready;
    logic [15:0] drain_count, pkt_word_hi, pkt_word_lo;
    logic [4:0] buffer_level;
    logic [31:0] rng = 32'h00000023;
    logic [43:0] e;
    logic [43:0] expq[$];
    int miscompares = 0, samples_checked = 0, k;
    always #2.5 clk = ~clk;
    mar_readback DUT (.*);
    mar_host_model host (.clk, .drain_start, .drain_count, .drain_busy, .pkt_ready);
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic longint lim(longint v, longint lo, longint hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    // expected packet: code, axis, servo velocity flag (never checked), has data, payload
    function automatic logic [43:0] model(input logic [7:0] c, input logic [1:0] a);
        longint p;
        bit h;
        bit s;
        p = 0;
        h = 1'b1;
        s = 1'b0;
        if (c == `MAR_FUNC_READ_POS) begin
            p = $signed(axis_position[a*32+:32]);
            if (scale_enable[a]) p = p * longint'(pos_scale[a*16+:16]);
            p = p + $signed(pos_offset[a*32+:32]);
            if (!stepper_variant) p = lim(p, -(2**30), 2**30 - 1);
            else if (op_mode == MAR_OP_VELOCITY) p = 0;
            else p = lim(p, -(longint'(1) << 31), (longint'(1) << 31) - 1);
        end else if (c == `MAR_FUNC_READ_VEL && !stepper_variant) begin
            p = lim($signed(axis_servo_vel[a*32+:32]) >>> 16, -16384, 16383);
            p = p & 32'h0000FFFF;
            s = 1'b1;
        end else if (c == `MAR_FUNC_READ_STEPS_VEL && stepper_variant) begin
            p = lim(longint'(axis_step_rate_req[a*32+:32]), 0, longint'(axis_max_rate[a*32+:32]));
            p = lim(p, 1, 1048576);
        end else h = 1'b0;
        return {c, a, s, h, p[31:0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [1:0] a);
        int j;
        @(negedge clk);
        cmd_valid = 1'b1;
        function_code = c;
        cmd_axis = a;
        for (j = 0; j < 50 && cmd_ready !== 1'b1; j++) @(negedge clk);
        expq.push_back(model(c, a));
        @(negedge clk);
        cmd_valid = 1'b0;
        axis_position = ~axis_position;
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // sampled values: the pop at this edge moves the buffer head
    always @(posedge clk) begin
        if ($sampled(rst_n) && $sampled(pkt_valid) === 1'b1 && $sampled(pkt_ready)) begin
            if (expq.size() == 0) chk("extra packet", 32'h0, 32'h1);
            else begin
                e = expq.pop_front();
                chk("code", e[43:36], $sampled(pkt_function_code));
                chk("axis", e[35:34], $sampled(pkt_axis));
                chk("has_data", e[32], $sampled(pkt_has_data));
                chk("word_hi", e[31:16], $sampled(pkt_word_hi));
                chk("word_lo", e[15:0], $sampled(pkt_word_lo));
            end
        end
    end
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        axis_position[63:32] = xs() >> 2;
        cmd(`MAR_FUNC_READ_POS, 2'h1);
        axis_position[127:96] = 32'h70000000;
        cmd(`MAR_FUNC_READ_POS, 2'h3);
        axis_servo_vel[31:0] = 32'hFFFE8000;
        cmd(`MAR_FUNC_READ_VEL, 2'h0);
        axis_servo_vel[31:0] = 32'h70000000;
        cmd(`MAR_FUNC_READ_VEL, 2'h0);
        cmd(8'h20, 2'h2);
        cmd(`MAR_FUNC_READ_STEPS_VEL, 2'h2);
        host.retrieve(16'h0003, 1'b1);
        host.retrieve(16'h0064, 1'b0);
        chk("level", 32'h0, buffer_level);
        stepper_variant = 1'b1;
        axis_position[31:0] = 32'h80000000;
        cmd(`MAR_FUNC_READ_POS, 2'h0);
        axis_position[31:0] = 32'h00000064;
        pos_scale[15:0] = 16'h0003;
        scale_enable = 4'h1;
        pos_offset[31:0] = 32'h00000005;
        cmd(`MAR_FUNC_READ_POS, 2'h0);
        scale_enable = 4'h0;
        pos_offset = '0;
        op_mode = MAR_OP_VELOCITY;
        cmd(`MAR_FUNC_READ_POS, 2'h0);
        op_mode = MAR_OP_ABSOLUTE;
        axis_step_rate_req = {xs(), xs(), 32'h00000000, 32'h01000000};
        axis_max_rate[95:64] = 32'h00001000;
        axis_dir_reverse = 4'(xs());
        for (k = 0; k < 4; k++) cmd(`MAR_FUNC_READ_STEPS_VEL, k[1:0]);
        cmd(`MAR_FUNC_READ_VEL, 2'h3);
        for (k = 0; k < 4; k++) chk("dir", axis_dir_reverse[k], axis_status[16*k]);
        for (k = 0; k < 40 && buffer_level !== 5'h10; k++) cmd(8'h30, k[1:0]);
        chk("ready when full", 32'h0, cmd_ready);
        host.retrieve(16'h0010, 1'b1);
        host.retrieve(16'h0000, 1'b0);
        chk("refused", 32'h1, drain_refused);
        cmd(`MAR_FUNC_READ_POS, 2'h2);
        @(negedge clk) rst_n = 1'b0;
        expq.delete();
        #1 chk("level in reset", 32'h0, buffer_level);
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        cmd(`MAR_FUNC_READ_POS, 2'h1);
        host.retrieve(16'h0001, 1'b0);
        print_verdict();
    end
endmodule
bind mar_readback mar_readback_props u_props (.clk, .rst_n, .cmd_valid, .cmd_ready, .drain_start,
    .drain_count, .drain_busy, .drain_refused, .pkt_valid, .pkt_ready, .axis_max_rate,
    .axis_dir_reverse, .axis_step_rate, .axis_status, .buffer_level);
